// ===== rtl/lsr_pkg.sv
// Package of register offsets, field layouts and reset values for the link status register group
package lsr_pkg;

	// Register offsets (byte addresses of an 8-bit map)
	localparam logic [7:0] LSR_OFS_LINE_FAULT  = 8'h14; // Test and line fault status
	localparam logic [7:0] LSR_OFS_RSVD_A      = 8'h15; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_B      = 8'h16; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_C      = 8'h17; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_D      = 8'h18; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_E      = 8'h19; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_F      = 8'h1a; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_G      = 8'h1b; // Reserved
	localparam logic [7:0] LSR_OFS_RSVD_H      = 8'h1c; // Reserved
	localparam logic [7:0] LSR_OFS_PIN_LEVEL   = 8'h1d; // Pin level mirror
	localparam logic [7:0] LSR_OFS_DEVICE_ID   = 8'h1e; // Device identifier
	localparam logic [7:0] LSR_OFS_CAP_REV     = 8'h1f; // Capability and revision
	localparam logic [7:0] LSR_OFS_IRQ_STATUS  = 8'h20; // Event status, write one to clear
	localparam logic [7:0] LSR_OFS_IRQ_MASK    = 8'h21; // Event mask

	// Reserved register read values
	localparam logic [7:0] LSR_RSVD_A_VAL = 8'h20; // Upper bits fixed, low bits read zero
	localparam logic [7:0] LSR_RSVD_B_VAL = 8'h30;
	localparam logic [7:0] LSR_RSVD_C_VAL = 8'h54;
	localparam logic [7:0] LSR_RSVD_D_VAL = 8'h30;
	localparam logic [7:0] LSR_RSVD_E_VAL = 8'hc8;
	localparam logic [7:0] LSR_RSVD_X_VAL = 8'h00; // Undefined reserved reads zero

	// Line fault codes
	localparam logic [1:0] LSR_FAULT_SUPPLY = 2'h0; // Shorted to supply
	localparam logic [1:0] LSR_FAULT_GROUND = 2'h1; // Shorted to ground
	localparam logic [1:0] LSR_FAULT_NORMAL = 2'h2; // Normal operation, reset value
	localparam logic [1:0] LSR_FAULT_OPEN   = 2'h3; // Disconnected

	// Field positions in the status register
	localparam int LSR_POS_PASS  = 7;
	localparam int LSR_POS_NEG   = 2;
	localparam int LSR_POS_POS   = 0;
	// Field positions in the pin level register
	localparam int LSR_POS_CABLE = 7;
	localparam int LSR_POS_COAX  = 6;
	localparam int LSR_POS_CHSEL = 5;
	localparam int LSR_POS_LCEN  = 4;
	// Field positions in the capability register
	localparam int LSR_POS_CAP   = 4;
	localparam int LSR_POS_REV   = 0;
	// Interrupt event bit positions
	localparam int LSR_EV_PASS   = 0; // Test pass rose
	localparam int LSR_EV_NEG    = 1; // Negative wire code changed
	localparam int LSR_EV_POS    = 2; // Positive wire code changed
	localparam int LSR_EV_PINS   = 3; // Any mirrored pin changed
	localparam int LSR_EV_W      = 4; // Number of events

	// Reset values
	localparam logic [LSR_EV_W-1:0] LSR_MASK_RST = 4'h0; // All events masked off
	localparam logic [7:0]          LSR_RDATA_RST = 8'h00;

	// Live inputs travelling together
	typedef struct packed {
		logic       pattern_test_pass_flag;          // Pattern test finished with success
		logic [1:0] neg_wire_fault_code;             // Negative wire fault code
		logic [1:0] pos_wire_fault_code;             // Positive wire fault code
	} lsr_link_s;

	typedef struct packed {
		logic cable_type_pin_level;                  // Cable type pin
		logic coax_select_pin_level;                 // Coax select pin
		logic ctrl_channel_select_level;             // Control channel select pin
		logic local_ctrl_channel_enable_level;       // Local control channel enable pin
	} lsr_pins_s;

endpackage

// ===== rtl/lsr_regs.sv
// Read-only link status, pin level and identification registers with event interrupt
//
// Behaviour
// - Top status bit reads pattern test passed
// - Negative wire fault code, reset normal
// - Positive wire fault code, reset normal
// - Four bits mirror the configuration pin levels
// - Fixed identifier, capability bit and revision
`timescale 1ns/1ps

module lsr_regs
	import lsr_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID_CODE = 8'h5a, // Arbitrary value
	parameter logic       CAP_FLAG       = 1'b0,  // Capability option
	parameter logic [3:0] REVISION_CODE  = 4'h1   // Arbitrary value
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	// Link test and fault inputs
	input  wire lsr_link_s  link_in,
	// Configuration pins
	input  wire lsr_pins_s  pins_in,
	// Interrupt
	output logic            irq
);

	lsr_link_s             link_q;      // Registered link status
	lsr_pins_s             pins_q;      // Registered pin levels
	logic [LSR_EV_W-1:0]   irq_status;  // Sticky events
	logic [LSR_EV_W-1:0]   irq_mask;    // Event enables
	logic [LSR_EV_W-1:0]   ev;          // Events this cycle
	logic [7:0]            next_rdata;  // Read mux result
	logic [LSR_EV_W-1:0]   clr;         // Write-one-clear bits
	logic [LSR_EV_W-1:0]   next_status; // Status as it stands after this edge
	logic [LSR_EV_W-1:0]   next_mask;   // Mask as it stands after this edge

	// Sample live status; fault codes start as normal so the first read is sane
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link_q.pattern_test_pass_flag <= 1'b0;
			link_q.neg_wire_fault_code    <= LSR_FAULT_NORMAL;
			link_q.pos_wire_fault_code    <= LSR_FAULT_NORMAL;
			pins_q                        <= '0;
		end else begin
			link_q <= link_in;
			pins_q <= pins_in;
		end
	end

	// Events: change of any sampled value; pass only on its rising edge
	always_comb begin
		ev = '0;
		ev[LSR_EV_PASS] = link_in.pattern_test_pass_flag & ~link_q.pattern_test_pass_flag;
		ev[LSR_EV_NEG]  = link_in.neg_wire_fault_code != link_q.neg_wire_fault_code;
		ev[LSR_EV_POS]  = link_in.pos_wire_fault_code != link_q.pos_wire_fault_code;
		ev[LSR_EV_PINS] = pins_in != pins_q;
	end

	// Clear mask from a write of ones to the status register
	always_comb begin
		clr = '0;
		if (wr_stb && addr == LSR_OFS_IRQ_STATUS) begin
			clr = wdata[LSR_EV_W-1:0];
		end
	end

	// Next status; a set in the clearing cycle wins so no event is lost
	always_comb begin
		next_status = (irq_status & ~clr) | ev;
	end

	// Sticky status
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_status <= '0;
		end else begin
			irq_status <= next_status;
		end
	end

	// Mask register, the only storage loaded from write data; other writes are dropped except status clears
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq_mask <= LSR_MASK_RST;
		end else if (wr_stb && addr == LSR_OFS_IRQ_MASK) begin
			irq_mask <= wdata[LSR_EV_W-1:0];
		end
	end

	// Mask as it stands after this edge, so a mask write moves the line at once
	always_comb begin
		next_mask = irq_mask;
		if (wr_stb && addr == LSR_OFS_IRQ_MASK) begin
			next_mask = wdata[LSR_EV_W-1:0];
		end
	end

	// Interrupt level registered from the status and mask of the same edge
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_status & next_mask);
		end
	end

	// Read decode; read-only values come from hardware, never from written data
	always_comb begin
		next_rdata = LSR_RDATA_RST;
		if (addr == LSR_OFS_LINE_FAULT) begin
			next_rdata[LSR_POS_PASS]           = link_q.pattern_test_pass_flag;
			next_rdata[LSR_POS_NEG +: 2]       = link_q.neg_wire_fault_code;
			next_rdata[LSR_POS_POS +: 2]       = link_q.pos_wire_fault_code;
		end else if (addr == LSR_OFS_RSVD_A) begin
			next_rdata = LSR_RSVD_A_VAL;
		end else if (addr == LSR_OFS_RSVD_B) begin
			next_rdata = LSR_RSVD_B_VAL;
		end else if (addr == LSR_OFS_RSVD_C) begin
			next_rdata = LSR_RSVD_C_VAL;
		end else if (addr == LSR_OFS_RSVD_D) begin
			next_rdata = LSR_RSVD_D_VAL;
		end else if (addr == LSR_OFS_RSVD_E) begin
			next_rdata = LSR_RSVD_E_VAL;
		end else if (addr == LSR_OFS_RSVD_F || addr == LSR_OFS_RSVD_G || addr == LSR_OFS_RSVD_H) begin
			next_rdata = LSR_RSVD_X_VAL;
		end else if (addr == LSR_OFS_PIN_LEVEL) begin
			next_rdata[LSR_POS_CABLE] = pins_q.cable_type_pin_level;
			next_rdata[LSR_POS_COAX]  = pins_q.coax_select_pin_level;
			next_rdata[LSR_POS_CHSEL] = pins_q.ctrl_channel_select_level;
			next_rdata[LSR_POS_LCEN]  = pins_q.local_ctrl_channel_enable_level;
		end else if (addr == LSR_OFS_DEVICE_ID) begin
			next_rdata = DEVICE_ID_CODE;
		end else if (addr == LSR_OFS_CAP_REV) begin
			next_rdata[LSR_POS_CAP]      = CAP_FLAG;
			next_rdata[LSR_POS_REV +: 4] = REVISION_CODE;
		end else if (addr == LSR_OFS_IRQ_STATUS) begin
			next_rdata[LSR_EV_W-1:0] = irq_status;
		end else if (addr == LSR_OFS_IRQ_MASK) begin
			next_rdata[LSR_EV_W-1:0] = irq_mask;
		end
	end

	// Read data valid only the cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata <= LSR_RDATA_RST;
		end else if (rd_stb) begin
			rdata <= next_rdata;
		end else begin
			rdata <= LSR_RDATA_RST;
		end
	end

	// Assertions, all on the one clock.
	// Read checks look one edge back, to the values that the read mux used;
	// looking at the live inputs instead would misfire on a read right after reset.

	// Pass flag read back in the top status bit
	AST_PASS_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_LINE_FAULT |=> rdata[7] == $past(link_q.pattern_test_pass_flag))
		else $error("pass flag read mismatch");

	// Negative wire code read back in its field
	AST_NEG_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_LINE_FAULT |=> rdata[3:2] == $past(link_q.neg_wire_fault_code))
		else $error("negative wire code read mismatch");

	// Positive wire code read back in its field
	AST_POS_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_LINE_FAULT |=> rdata[1:0] == $past(link_q.pos_wire_fault_code))
		else $error("positive wire code read mismatch");

	// Both fault codes leave reset as normal
	AST_FAULT_RESET: assert property (@(posedge clk)
		$rose(rst_b) |-> link_q.neg_wire_fault_code == LSR_FAULT_NORMAL
			&& link_q.pos_wire_fault_code == LSR_FAULT_NORMAL)
		else $error("fault codes not normal after reset");

	// Pin levels in the upper nibble, lower nibble zero
	AST_PIN_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_PIN_LEVEL |=> rdata == {$past(pins_q), 4'h0})
		else $error("pin level read mismatch");

	// Identifier is a fixed byte
	AST_ID_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_DEVICE_ID |=> rdata == DEVICE_ID_CODE)
		else $error("identifier read mismatch");

	// Capability bit and revision, upper bits zero
	AST_CAP_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_CAP_REV |=> rdata == {3'h0, CAP_FLAG, REVISION_CODE})
		else $error("capability read mismatch");

	// Only a mask write may move the mask; read-only and reserved writes leave it
	AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rst_b)
		wr_stb && addr != LSR_OFS_IRQ_MASK |=> irq_mask == $past(irq_mask))
		else $error("write outside the mask changed it");

	// A write to the status address does not disturb the sampled link state
	AST_WRITE_STATUS_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
		wr_stb && addr == LSR_OFS_LINE_FAULT |=> link_q == $past(link_in))
		else $error("write to status disturbed link state");

	// Interrupt line is high exactly while an unmasked status bit is set
	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
		irq == |(irq_status & irq_mask))
		else $error("interrupt level wrong");

	// Reserved byte with fixed upper bits
	AST_RSVD_A_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_RSVD_A |=> rdata == LSR_RSVD_A_VAL)
		else $error("reserved byte a read mismatch");

	// Reserved fixed byte
	AST_RSVD_B_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_RSVD_B |=> rdata == LSR_RSVD_B_VAL)
		else $error("reserved byte b read mismatch");

	// Reserved fixed byte
	AST_RSVD_C_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_RSVD_C |=> rdata == LSR_RSVD_C_VAL)
		else $error("reserved byte c read mismatch");

	// Reserved fixed byte
	AST_RSVD_D_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_RSVD_D |=> rdata == LSR_RSVD_D_VAL)
		else $error("reserved byte d read mismatch");

	// Reserved fixed byte
	AST_RSVD_E_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_RSVD_E |=> rdata == LSR_RSVD_E_VAL)
		else $error("reserved byte e read mismatch");

	// Undefined reserved bytes read zero
	AST_RSVD_X_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && (addr == LSR_OFS_RSVD_F || addr == LSR_OFS_RSVD_G || addr == LSR_OFS_RSVD_H)
			|=> rdata == LSR_RSVD_X_VAL)
		else $error("undefined reserved byte read mismatch");

	// Addresses outside the group read zero
	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && (addr < LSR_OFS_LINE_FAULT || addr > LSR_OFS_IRQ_MASK) |=> rdata == LSR_RDATA_RST)
		else $error("unmapped read not zero");

	// Read data stand only in the cycle after a strobe
	AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
		!rd_stb |=> rdata == LSR_RDATA_RST)
		else $error("read data outside the answer cycle");

	// Event status read back zero extended
	AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_IRQ_STATUS |=> rdata == 8'($past(irq_status)))
		else $error("event status read mismatch");

	// Mask read back zero extended
	AST_MASK_READ: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_IRQ_MASK |=> rdata == 8'($past(irq_mask)))
		else $error("mask read mismatch");

	// A mask write lands at the next edge
	AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		wr_stb && addr == LSR_OFS_IRQ_MASK |=> irq_mask == $past(wdata[LSR_EV_W-1:0]))
		else $error("mask write did not land");

	// Every event sets its status bit, even in a clearing cycle
	AST_STATUS_SET: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b && |ev |=> (irq_status & $past(ev)) == $past(ev))
		else $error("event lost");

	// Writing ones clears the bits that no event sets at the same edge
	AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		wr_stb && addr == LSR_OFS_IRQ_STATUS |=> (irq_status & $past(clr & ~ev)) == '0)
		else $error("status bit not cleared");

	// Without a clear, set status bits stay set
	AST_STATUS_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		!(wr_stb && addr == LSR_OFS_IRQ_STATUS) |=> (irq_status & $past(irq_status)) == $past(irq_status))
		else $error("status bit dropped without a clear");

	// A rising pass flag raises its event bit
	AST_PASS_EVENT: assert property (@(posedge clk) disable iff (!rst_b)
		link_in.pattern_test_pass_flag && !link_q.pattern_test_pass_flag |=> irq_status[LSR_EV_PASS])
		else $error("pass event not recorded");

	// Interrupt side leaves reset quiet
	AST_IRQ_RESET: assert property (@(posedge clk)
		$rose(rst_b) |-> !irq && irq_status == '0 && irq_mask == LSR_MASK_RST && rdata == LSR_RDATA_RST)
		else $error("interrupt state not clear after reset");

	// Pass flag leaves reset low
	AST_PASS_RESET: assert property (@(posedge clk)
		$rose(rst_b) |-> !link_q.pattern_test_pass_flag)
		else $error("pass flag set after reset");

	// Pin mirror leaves reset low
	AST_PIN_RESET: assert property (@(posedge clk)
		$rose(rst_b) |-> pins_q == '0)
		else $error("pin mirror not clear after reset");

	// Reserved status bits read zero
	AST_STATUS_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
		rd_stb && addr == LSR_OFS_LINE_FAULT |=> rdata[6:4] == 3'h0)
		else $error("reserved status bits not zero");

	// Link state follows its inputs one edge late once out of reset
	AST_STATUS_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b && $past(rst_b) |-> link_q == $past(link_in))
		else $error("link state does not follow inputs");

	// Pin mirror follows its pins one edge late once out of reset
	AST_PIN_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
		rst_b && $past(rst_b) |-> pins_q == $past(pins_in))
		else $error("pin mirror does not follow pins");

endmodule

// ===== verif/tb_lsr_regs.sv
// Self-checking testbench for the link status, pin level and identification registers
`timescale 1ns/1ps

module tb_lsr_regs;
	import lsr_pkg::*;

	localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
	localparam logic       CAP     = 1'b1;  // Capability option under test
	localparam logic [3:0] REV     = 4'h6;  // Arbitrary value

	logic       clk      = 1'b0;    // 50 MHz clock
	logic       rst_b    = 1'b0;    // Synchronous reset, active low
	logic [7:0] addr     = 8'h00;   // Register address
	logic [7:0] wdata    = 8'h00;   // Write data
	logic       wr_stb   = 1'b0;    // Write strobe
	logic       rd_stb   = 1'b0;    // Read strobe
	logic [7:0] rdata;              // Read data
	lsr_link_s  link_in  = 5'h0a;   // Test pass low, both wires normal
	lsr_pins_s  pins_in  = 4'h0;    // Configuration pins
	logic       irq;                // Interrupt output
	int         fail_count = 0;     // Mismatches
	int         num_checks = 0;     // Comparisons made
	int         cyc        = 0;     // Cycles since start, for the hang guard
	logic [15:0] rnd       = 16'hfa21; // Random state, fixed seed

	lsr_regs #(.DEVICE_ID_CODE(ID_CODE), .CAP_FLAG(CAP), .REVISION_CODE(REV)) uut (
		.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .link_in(link_in), .pins_in(pins_in), .irq(irq));

	// Clock toggles every half period
	always #10 clk = ~clk;

	// Sixteen-bit Fibonacci shift register for stimulus
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Expected read value of one address from the live inputs
	function automatic logic [7:0] exp_reg(input logic [7:0] a);
		case (a)
			8'h14: return {link_in.pattern_test_pass_flag, 3'b000, link_in.neg_wire_fault_code,
				link_in.pos_wire_fault_code};
			8'h15: return 8'h20;         // Don't-care bits settle to zero
			8'h16: return 8'h30;
			8'h17: return 8'h54;
			8'h18: return 8'h30;
			8'h19: return 8'hc8;
			8'h1d: return {pins_in, 4'h0};
			8'h1e: return ID_CODE;
			8'h1f: return {3'b000, CAP, REV};
			default: return 8'h00;      // Undefined and unmapped places read zero
		endcase
	endfunction

	// Compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	// One-cycle read strobe; data stand only in the following cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk(rdata, e);
	endtask

	// Settle irq a few cycles and compare it
	task automatic chk_irq(input logic e);
		repeat (3) @(posedge clk);
		#1 chk({7'h00, irq}, {7'h00, e});
	endtask

	// Verdict, reached from the main sequence or the hang guard
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard: far above the fewer than a thousand cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		// Reset values: normal fault codes, no pass, mask clear
		for (int i = 0; i < 16; i++) rd(8'h12 + 8'(i), (i >= 14) ? 8'h00 : exp_reg(8'h12 + 8'(i)));
		// Random inputs, random writes to read-only places, read-only map read back
		for (int n = 0; n < 24; n++) begin
			rnd = lfsr_next(rnd);
			@(posedge clk);
			link_in <= rnd[4:0];
			pins_in <= rnd[8:5];
			wr(8'h14 + 8'(rnd[15:12] % 4'd12), rnd[7:0] ^ rnd[15:8]);
			repeat (2) @(posedge clk);
			for (int a = 8'h12; a < 8'h20; a++) rd(8'(a), exp_reg(8'(a)));
			rd(8'hff, 8'h00);
		end
		// Every fault code on both wires, including the corners
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			link_in <= {1'b1, 2'(c), 2'(3 - c)};
			repeat (2) @(posedge clk);
			rd(8'h14, exp_reg(8'h14));
		end
		// Interrupt: quiet inputs, clear, unmask pass event, raise it
		@(posedge clk);
		link_in <= 5'h0a;
		pins_in <= 4'h0;
		repeat (3) @(posedge clk);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h00);
		wr(8'h21, 8'h01);
		rd(8'h21, 8'h01);
		chk_irq(1'b0);
		@(posedge clk);
		link_in.pattern_test_pass_flag <= 1'b1;
		chk_irq(1'b1);
		@(posedge clk);
		link_in.neg_wire_fault_code <= 2'h1;
		pins_in <= 4'h8;
		repeat (3) @(posedge clk);
		rd(8'h20, 8'h0b);
		// Masking drops the line, status stays sticky
		wr(8'h21, 8'h04);
		chk_irq(1'b0);
		@(posedge clk);
		link_in.pos_wire_fault_code <= 2'h3;
		chk_irq(1'b1);
		wr(8'h20, 8'h0f);
		chk_irq(1'b0);
		rd(8'h20, 8'h00);
		rd(8'h14, 8'h87);
		conclude();
	end
endmodule
